// ### rtl/dmt_pkg.sv
// Package with constants and register map for the dual 8-bit modulo timer.
// Function
// - First timer pulse: /16, /512, /64, external pin
// - Second timer pulse: /128, /8192, /16, first match
// - Reset: second timer runs, /128 selected
// - Reset: first timer mode bits all zero
// - Eight-bit up counters start at zero, count pulses
// - Count clears on reset, match, clear bit
// - First clear bit also clears first irq flag
// - Clear bits self-clear and read as zero
// - Run bit starts, stops, reads running state
// - Modulo registers reset to ff
// - Match when count equals modulo and pulse arrives
// - Match clears count and sets irq flag
// - Irq taken when globally enabled and flag enabled
// - Match-fed second timer forms sixteen-bit timer
// - Modulo loaded by peripheral writes at 02, 03
// - Modulo load takes low byte of buffer
// - Modulo load keeps counting, reads nothing
// - Count registers cannot be written
// - First mode at 11: run, clear, select
// - Both counts read at 45 as word
// - Counts hold during read, pulse applied after
// - Clear bit leaves prescaler running
package dmt_pkg;
   localparam logic [6:0] DMT_PADDR_MOD0 = 7'h02;
   localparam logic [6:0] DMT_PADDR_MOD1 = 7'h03;
   localparam logic [6:0] DMT_PADDR_COUNT = 7'h45;
   localparam logic [6:0] DMT_RF_MODE0 = 7'h11;
   localparam logic [6:0] DMT_RF_MODE1 = 7'h12;
   localparam int DMT_BIT_RUN = 3;
   localparam int DMT_BIT_CLR = 2;
   localparam logic [3:0] DMT_MODE0_RST = 4'h0;
   localparam logic [3:0] DMT_MODE1_RST = 4'h8;
   localparam logic [7:0] DMT_MOD_RST = 8'hff;
   localparam logic [7:0] DMT_CNT_RST = 8'h00;
   localparam int DMT_PRE_W = 13;
   localparam int DMT_DIV16_BIT = 3;
   localparam int DMT_DIV64_BIT = 5;
   localparam int DMT_DIV128_BIT = 6;
   localparam int DMT_DIV512_BIT = 8;
   localparam int DMT_DIV8192_BIT = 12;
   localparam logic [1:0] DMT_SEL0_D16 = 2'h0;
   localparam logic [1:0] DMT_SEL0_D512 = 2'h1;
   localparam logic [1:0] DMT_SEL0_D64 = 2'h2;
   localparam logic [1:0] DMT_SEL0_EXT = 2'h3;
   localparam logic [1:0] DMT_SEL1_D128 = 2'h0;
   localparam logic [1:0] DMT_SEL1_D8192 = 2'h1;
   localparam logic [1:0] DMT_SEL1_D16 = 2'h2;
   localparam logic [1:0] DMT_SEL1_CASC = 2'h3;
endpackage : dmt_pkg

// ### rtl/dmt_chan.sv
// One eight-bit modulo counter channel with comparator, clear and irq flag.
`timescale 1ns/1ps
module dmt_chan (
   input wire logic mclk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic pulse, // Selected count pulse, one cycle.
   input wire logic run, // Counting enabled.
   input wire logic clr, // Counter clear strobe.
   input wire logic hold, // Count read in progress.
   input wire logic mod_we, // Modulo load strobe.
   input wire logic [7:0] mod_wdata, // Modulo load data.
   input wire logic irq_ack, // Irq accepted.
   output logic [7:0] count, // Count register.
   output logic match, // Match pulse.
   output logic irq_flag // Irq request flag.
);
   import dmt_pkg::*;
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] modv;
      logic pend;
      logic match;
      logic irq;
   } dmt_chan_st_t;
   dmt_chan_st_t st_reg, st_next;
   logic eff;
   always_comb begin
      st_next = st_reg;
      st_next.match = 1'b0;
      eff = run & (pulse | st_reg.pend) & ~hold;
      if (hold && run && pulse) begin
         st_next.pend = 1'b1;
      end else if (eff) begin
         st_next.pend = 1'b0;
      end
      if (mod_we) begin
         st_next.modv = mod_wdata;
      end
      if (eff && st_reg.cnt == st_reg.modv) begin
         st_next.cnt = DMT_CNT_RST;
         st_next.match = 1'b1;
      end else if (eff) begin
         st_next.cnt = st_reg.cnt + 8'h01;
      end
      if (clr) begin
         st_next.cnt = DMT_CNT_RST;
         st_next.pend = 1'b0;
      end
      if (irq_ack) begin
         st_next.irq = 1'b0;
      end
      if (st_next.match) begin
         st_next.irq = 1'b1;
      end else if (clr) begin
         st_next.irq = 1'b0;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{cnt: DMT_CNT_RST, modv: DMT_MOD_RST, pend: 1'b0, match: 1'b0, irq: 1'b0};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end
   assign count = st_reg.cnt;
   assign match = st_reg.match;
   assign irq_flag = st_reg.irq;

   a_cnt_idle_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && !run && !clr |=> st_reg.cnt == $past(st_reg.cnt))
      else $error("count moved while stopped");
   a_match_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      st_reg.match |-> st_reg.cnt == DMT_CNT_RST && st_reg.irq)
      else $error("match did not clear count or set flag");
endmodule : dmt_chan

// ### rtl/dmt_timer.sv
// Top of the dual 8-bit modulo timer with mode registers and peripheral transfers.
`timescale 1ns/1ps
module dmt_timer (
   input wire logic mclk, // System clock, 40 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; state frozen while low.
   input wire logic ext_pin, // External count pin, asynchronous.
   input wire logic rf_we, // Register-file write strobe.
   input wire logic rf_re, // Register-file read strobe.
   input wire logic [6:0] rf_addr, // Register-file address.
   input wire logic [3:0] rf_wdata, // Register-file write nibble.
   input wire logic pw_op, // Peripheral write transfer strobe.
   input wire logic pr_op, // Peripheral read transfer strobe.
   input wire logic [6:0] p_addr, // Peripheral address.
   input wire logic [15:0] pdb_wdata, // Peripheral data buffer contents.
   input wire logic gie, // Global interrupt enable.
   input wire logic irq_en0, // First timer interrupt enable.
   input wire logic irq_en1, // Second timer interrupt enable.
   input wire logic irq_ack0, // First timer interrupt accepted.
   input wire logic irq_ack1, // Second timer interrupt accepted.
   output logic [3:0] rf_rdata, // Register-file read nibble.
   output logic rf_rvalid, // Register-file read valid.
   output logic [15:0] pdb_rdata, // Peripheral read data.
   output logic pdb_rvalid, // Peripheral read valid.
   output logic irq_flag0, // First timer irq request flag.
   output logic irq_flag1, // Second timer irq request flag.
   output logic irq_req0, // First timer irq request, gated.
   output logic irq_req1 // Second timer irq request, gated.
);
   import dmt_pkg::*;
   typedef struct packed {
      logic [DMT_PRE_W-1:0] pre;
      logic [DMT_PRE_W-1:0] pre_d;
      logic [2:0] ext_sy;
      logic [3:0] mode0;
      logic [3:0] mode1;
      logic clr0;
      logic clr1;
      logic [3:0] rdata;
      logic rvalid;
      logic [15:0] pdata;
      logic pvalid;
      logic req0;
      logic req1;
      logic flag0;
      logic flag1;
   } dmt_top_st_t;
   dmt_top_st_t st_reg, st_next;
   logic [7:0] cnt0, cnt1;
   logic m0, m1, f0, f1, p0, p1, hold;
   logic [DMT_PRE_W-1:0] fall;

   function automatic logic sel_pulse(input logic [1:0] sel, input logic [3:0] src);
      sel_pulse = src[sel];
   endfunction : sel_pulse

   assign fall = st_reg.pre_d & ~st_reg.pre;
   assign hold = pr_op && p_addr == DMT_PADDR_COUNT;
   assign p0 = sel_pulse(st_reg.mode0[1:0], {st_reg.ext_sy[2] & ~st_reg.ext_sy[1], fall[DMT_DIV64_BIT],
      fall[DMT_DIV512_BIT], fall[DMT_DIV16_BIT]});
   assign p1 = sel_pulse(st_reg.mode1[1:0], {m0, fall[DMT_DIV16_BIT], fall[DMT_DIV8192_BIT], fall[DMT_DIV128_BIT]});

   dmt_chan u_ch0 (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .pulse(p0), .run(st_reg.mode0[DMT_BIT_RUN]),
      .clr(st_reg.clr0), .hold(hold),
      .mod_we(pw_op && p_addr == DMT_PADDR_MOD0), .mod_wdata(pdb_wdata[7:0]),
      .irq_ack(irq_ack0), .count(cnt0), .match(m0), .irq_flag(f0)
   );
   dmt_chan u_ch1 (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .pulse(p1), .run(st_reg.mode1[DMT_BIT_RUN]),
      .clr(st_reg.clr1), .hold(hold),
      .mod_we(pw_op && p_addr == DMT_PADDR_MOD1), .mod_wdata(pdb_wdata[7:0]),
      .irq_ack(irq_ack1), .count(cnt1), .match(m1), .irq_flag(f1)
   );

   always_comb begin
      st_next = st_reg;
      st_next.pre = st_reg.pre + 13'h0001;
      st_next.pre_d = st_reg.pre;
      st_next.ext_sy = {st_reg.ext_sy[1:0], ext_pin};
      st_next.clr0 = 1'b0;
      st_next.clr1 = 1'b0;
      if (rf_we && rf_addr == DMT_RF_MODE0) begin
         st_next.mode0 = {rf_wdata[3], 1'b0, rf_wdata[1:0]};
         st_next.clr0 = rf_wdata[DMT_BIT_CLR];
      end
      if (rf_we && rf_addr == DMT_RF_MODE1) begin
         st_next.mode1 = {rf_wdata[3], 1'b0, rf_wdata[1:0]};
         st_next.clr1 = rf_wdata[DMT_BIT_CLR];
      end
      st_next.rvalid = rf_re;
      if (rf_addr == DMT_RF_MODE0) begin
         st_next.rdata = st_reg.mode0;
      end else if (rf_addr == DMT_RF_MODE1) begin
         st_next.rdata = st_reg.mode1;
      end else begin
         st_next.rdata = 4'h0;
      end
      st_next.pvalid = pr_op;
      st_next.pdata = (p_addr == DMT_PADDR_COUNT) ? {cnt1, cnt0} : 16'h0000;
      st_next.req0 = gie & irq_en0 & f0;
      st_next.req1 = gie & irq_en1 & f1;
      st_next.flag0 = f0;
      st_next.flag1 = f1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{pre: '0, pre_d: '0, ext_sy: 3'h0, mode0: DMT_MODE0_RST, mode1: DMT_MODE1_RST,
            clr0: 1'b0, clr1: 1'b0, rdata: 4'h0, rvalid: 1'b0, pdata: 16'h0000, pvalid: 1'b0,
            req0: 1'b0, req1: 1'b0, flag0: 1'b0, flag1: 1'b0};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign rf_rdata = st_reg.rdata;
   assign rf_rvalid = st_reg.rvalid;
   assign pdb_rdata = st_reg.pdata;
   assign pdb_rvalid = st_reg.pvalid;
   assign irq_flag0 = st_reg.flag0;
   assign irq_flag1 = st_reg.flag1;
   assign irq_req0 = st_reg.req0;
   assign irq_req1 = st_reg.req1;

   // A fresh clear write in the same cycle legally raises the strobe again.
   a_clr_self: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && st_reg.clr0 && !(rf_we && rf_addr == DMT_RF_MODE0)
      |=> !st_reg.clr0 && st_reg.mode0[DMT_BIT_CLR] == 1'b0)
      else $error("clear bit did not self clear");
   a_clr_count: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && st_reg.clr0 |=> cnt0 == DMT_CNT_RST)
      else $error("clear did not zero count");
   a_clr_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && st_reg.clr0 && !m0 |=> !f0 || m0)
      else $error("clear did not drop flag");
   a_req_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && !gie |=> !irq_req0 && !irq_req1)
      else $error("request raised without global enable");
   a_read_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && hold && !st_reg.clr0 |=> cnt0 == $past(cnt0))
      else $error("count moved during read");
   a_casc_step: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && m0 && !hold && st_reg.mode1[DMT_BIT_RUN] && st_reg.mode1[1:0] == DMT_SEL1_CASC && !st_reg.clr1
      && !m1 && cnt1 != 8'hff |-> ##1 (cnt1 == $past(cnt1) + 8'h01 || m1 || !ce))
      else $error("cascade did not advance");
   a_mod_load: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && pw_op && p_addr == DMT_PADDR_MOD0 && st_reg.mode0[DMT_BIT_RUN] && p0 && !hold && !st_reg.clr0
      && cnt0 != 8'hff |=> cnt0 != DMT_CNT_RST || m0 || $past(cnt0) == 8'hff)
      else $error("modulo load stopped counting");
   a_count_read: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && pr_op && p_addr == DMT_PADDR_COUNT |=> pdb_rvalid && pdb_rdata == {$past(cnt1), $past(cnt0)})
      else $error("count read word wrong");
   c_match0: cover property (@(posedge mclk) m0);
   c_casc: cover property (@(posedge mclk) m1 && st_reg.mode1[1:0] == DMT_SEL1_CASC);
   c_read: cover property (@(posedge mclk) hold && p0);
endmodule : dmt_timer

// ### dv/dmt_core_bfm.sv
// Processor-core model issuing register-file and peripheral transfers.
`timescale 1ns/1ps
module dmt_core_bfm (
   input wire logic mclk, // System clock.
   output logic rf_we, // Register-file write.
   output logic rf_re, // Register-file read.
   output logic [6:0] rf_addr, // Register-file address.
   output logic [3:0] rf_wdata, // Register-file nibble.
   output logic pw_op, // Peripheral write.
   output logic pr_op, // Peripheral read.
   output logic [6:0] p_addr, // Peripheral address.
   output logic [15:0] pdb_wdata, // Data buffer.
   input wire logic [3:0] rf_rdata, // Read nibble.
   input wire logic rf_rvalid, // Read nibble valid.
   input wire logic [15:0] pdb_rdata, // Read word.
   input wire logic pdb_rvalid // Read word valid.
);
   import dmt_pkg::*;
   initial begin
      {pr_op, pw_op, rf_re, rf_we} = 4'h0;
      rf_addr = 7'h00;
      p_addr = 7'h00;
      rf_wdata = 4'h0;
      pdb_wdata = 16'h0000;
   end
   // Kinds: 0 register write, 1 register read, 2 peripheral write, 3 peripheral read.
   task xfer(input logic [1:0] k, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
      @(negedge mclk);
      rf_addr = a;
      p_addr = a;
      rf_wdata = d[3:0];
      pdb_wdata = d;
      {pr_op, pw_op, rf_re, rf_we} = 4'h1 << k;
      @(negedge mclk);
      // The answer stands only in the cycle after the taking edge; a missing valid reads as all ones.
      if (k[0] && (k[1] ? pdb_rvalid : rf_rvalid) === 1'b1) begin
         q = k[1] ? pdb_rdata : {12'h000, rf_rdata};
      end else begin
         q = 16'hffff;
      end
      {pr_op, pw_op, rf_re, rf_we} = 4'h0;
      rf_wdata = ~d[3:0];
      pdb_wdata = ~d;
   endtask : xfer
endmodule : dmt_core_bfm

// ### dv/dmt_timer_tb_top.sv
// Self-checking bench for the dual modulo timer.
`timescale 1ns/1ps
module dmt_timer_tb_top;
   import dmt_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic ext_pin = 1'b0;
   logic gie = 1'b1;
   logic irq_en0 = 1'b0;
   logic irq_en1 = 1'b0;
   logic irq_ack0 = 1'b0;
   logic irq_ack1 = 1'b0;
   logic rf_we, rf_re, pw_op, pr_op, irq_flag0, irq_req0;
   logic rf_rvalid, pdb_rvalid, irq_flag1, irq_req1;
   time t0;
   logic [6:0] rf_addr, p_addr;
   logic [3:0] rf_wdata, rf_rdata;
   logic [15:0] pdb_wdata, pdb_rdata, q, w;
   int error_cnt = 0;
   int checks = 0;
   int n;
   always #12.5 mclk = ~mclk;
   dmt_timer u_dmt_timer (.mclk(mclk), .rst_n(rst_n), .ce(ce), .ext_pin(ext_pin), .rf_we(rf_we),
      .rf_re(rf_re), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .pw_op(pw_op), .pr_op(pr_op),
      .p_addr(p_addr), .pdb_wdata(pdb_wdata), .gie(gie), .irq_en0(irq_en0), .irq_en1(irq_en1),
      .irq_ack0(irq_ack0), .irq_ack1(irq_ack1), .rf_rdata(rf_rdata), .rf_rvalid(rf_rvalid),
      .pdb_rdata(pdb_rdata), .pdb_rvalid(pdb_rvalid), .irq_flag0(irq_flag0), .irq_flag1(irq_flag1),
      .irq_req0(irq_req0), .irq_req1(irq_req1));
   dmt_core_bfm u_dmt_core_bfm (.mclk(mclk), .rf_we(rf_we), .rf_re(rf_re), .rf_addr(rf_addr),
      .rf_wdata(rf_wdata), .pw_op(pw_op), .pr_op(pr_op), .p_addr(p_addr), .pdb_wdata(pdb_wdata),
      .rf_rdata(rf_rdata), .rf_rvalid(rf_rvalid), .pdb_rdata(pdb_rdata), .pdb_rvalid(pdb_rvalid));
   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task step(input int k);
      repeat (k) @(negedge mclk);
      n += k;
   endtask : step
   task ext_pulses(input int k);
      repeat (k) begin
         ext_pin = 1'b1;
         repeat (4) @(negedge mclk);
         ext_pin = 1'b0;
         repeat (4) @(negedge mclk);
      end
      repeat (6) @(negedge mclk);
   endtask : ext_pulses
   task t_reset;
      u_dmt_core_bfm.xfer(2'h1, DMT_RF_MODE0, 16'h0000, q);
      chk(q, 16'h0000, "first mode reset");
      u_dmt_core_bfm.xfer(2'h1, DMT_RF_MODE1, 16'h0000, q);
      chk(q, 16'h0008, "second mode reset");
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_MOD0, 16'h0000, q);
      chk(q, 16'h0000, "modulo unreadable");
   endtask : t_reset
   task t_stop;
      u_dmt_core_bfm.xfer(2'h0, DMT_RF_MODE1, 16'h0000, q);
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_COUNT, 16'h0000, w);
      chk({8'h00, w[7:0]}, 16'h0000, "idle first count");
      u_dmt_core_bfm.xfer(2'h2, DMT_PADDR_COUNT, 16'h5a5a, q);
      repeat (300) @(negedge mclk);
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_COUNT, 16'h0000, q);
      chk(q, w, "counts frozen");
   endtask : t_stop
   task t_match;
      u_dmt_core_bfm.xfer(2'h2, DMT_PADDR_MOD0, 16'hab03, q);
      u_dmt_core_bfm.xfer(2'h0, DMT_RF_MODE0, 16'h000c, q);
      u_dmt_core_bfm.xfer(2'h1, DMT_RF_MODE0, 16'h0000, q);
      chk(q, 16'h0008, "mode readback");
      n = 0;
      while (irq_flag0 !== 1'b1 && n < 600) step(1);
      n = 0;
      step(2);
      chk({15'h0000, irq_req0}, 16'h0000, "request masked");
      irq_en0 = 1'b1;
      step(2);
      chk({15'h0000, irq_req0}, 16'h0001, "request raised");
      irq_ack0 = 1'b1;
      step(1);
      irq_ack0 = 1'b0;
      step(2);
      chk({15'h0000, irq_flag0}, 16'h0000, "ack clears flag");
      while (irq_flag0 !== 1'b1 && n < 600) step(1);
      chk(n[15:0], 16'h0040, "match period");
      t0 = $time;
      irq_ack0 = 1'b1;
      step(1);
      irq_ack0 = 1'b0;
      // A modulo load landing on a count pulse must not swallow that pulse: eight pulses of 16 cycles.
      @(posedge u_dmt_timer.p0);
      u_dmt_core_bfm.xfer(2'h2, DMT_PADDR_MOD0, 16'h0007, q);
      n = 0;
      while (irq_flag0 !== 1'b1 && n < 600) step(1);
      chk(16'($time - t0), 16'h0c80, "load keeps counting");
   endtask : t_match
   task t_clear;
      u_dmt_core_bfm.xfer(2'h0, DMT_RF_MODE0, 16'h0004, q);
      repeat (3) @(negedge mclk);
      chk({15'h0000, irq_flag0}, 16'h0000, "clear drops flag");
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_COUNT, 16'h0000, q);
      chk({8'h00, q[7:0]}, 16'h0000, "clear zeroes count");
   endtask : t_clear
   task t_ext;
      u_dmt_core_bfm.xfer(2'h2, DMT_PADDR_MOD0, 16'h00ff, q);
      u_dmt_core_bfm.xfer(2'h0, DMT_RF_MODE0, 16'h000f, q);
      ext_pulses(5);
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_COUNT, 16'h0000, q);
      chk({8'h00, q[7:0]}, 16'h0005, "pin pulses");
   endtask : t_ext
   task t_casc;
      u_dmt_core_bfm.xfer(2'h2, DMT_PADDR_MOD0, 16'h0001, q);
      u_dmt_core_bfm.xfer(2'h2, DMT_PADDR_MOD1, 16'h0002, q);
      u_dmt_core_bfm.xfer(2'h0, DMT_RF_MODE1, 16'h000f, q);
      u_dmt_core_bfm.xfer(2'h0, DMT_RF_MODE0, 16'h000f, q);
      u_dmt_core_bfm.xfer(2'h1, DMT_RF_MODE1, 16'h0000, q);
      chk(q, 16'h000b, "second mode readback");
      ext_pulses(5);
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_COUNT, 16'h0000, q);
      chk(q, 16'h0201, "cascaded word");
      chk({15'h0000, irq_flag1}, 16'h0000, "second flag idle");
      ext_pulses(1);
      chk({15'h0000, irq_flag1}, 16'h0001, "second match flag");
      irq_en1 = 1'b1;
      step(2);
      chk({15'h0000, irq_req1}, 16'h0001, "second request");
      u_dmt_core_bfm.xfer(2'h3, DMT_PADDR_COUNT, 16'h0000, q);
      chk(q, 16'h0000, "both wrapped");
   endtask : t_casc
   task close_out;
      if (error_cnt == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      t_reset;
      t_stop;
      t_match;
      t_clear;
      t_ext;
      t_casc;
      close_out;
   end
   initial begin
      repeat (20000) @(negedge mclk);
      error_cnt++;
      close_out;
   end
endmodule : dmt_timer_tb_top
